// [scs_defs.svh]
/*
 * scs_defs.svh: offsets, field positions, codes, reset values and counts
 * for the system clock source select block.
 * assumes: included by the package and the design file by its bare name.
 */
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SCS_OFS_REQUEST 12'h000
`define SCS_OFS_CURRENT 12'h004
`define SCS_OFS_SWITCH 12'h008
`define SCS_OFS_READY 12'h00c
`define SCS_OFS_MANUAL 12'h010
`define SCS_OFS_FREQ 12'h014
`define SCS_OFS_TRIM 12'h018
`define SCS_OFS_DONE 12'h01c

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SCS_SRC_LSB 4
`define SCS_HOLD_BIT 7
`define SCS_NSR_BIT 4
`define SCS_ORDY_BIT 3

// ----------------------------------------------------------------------
// source codes
// ----------------------------------------------------------------------
`define SCS_SRC_HF2X 3'h0
`define SCS_SRC_EXT4X 3'h1
`define SCS_SRC_SEC 3'h2
`define SCS_SRC_LF 3'h3
`define SCS_SRC_EXT 3'h4
`define SCS_SRC_HF 3'h6

// oscillator vector bit positions
`define SCS_O_EXT 0
`define SCS_O_HF 1
`define SCS_O_LF 2
`define SCS_O_SEC 3
`define SCS_O_PLL4 4
`define SCS_O_PLL2 5

// external mode codes
`define SCS_MODE_ECH 3'h0
`define SCS_MODE_ECM 3'h1
`define SCS_MODE_ECL 3'h2
`define SCS_MODE_LP 3'h3
`define SCS_MODE_XT 3'h4
`define SCS_MODE_HS 3'h5

// fast rc frequency codes
`define SCS_FRQ_1M 4'h0
`define SCS_FRQ_8M 4'h4
`define SCS_FRQ_12M 4'h5
`define SCS_FRQ_16M 4'h6

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define SCS_TRIM_RST 6'h00
`define SCS_OST_LAST 10'h3ff
`define SCS_DIV_MAX 4'h9

`endif

// [scs_pkg.sv]
/*
 * scs_pkg.sv: types of the system clock source select block.
 * assumes: scs_defs.svh is on the include path.
 */
package scs_pkg;
`include "scs_defs.svh"

    // switch sequencer, gray coded along idle-wait-gap
    typedef enum logic [1:0] {
        SCS_SW_IDLE = 2'b00,
        SCS_SW_WAIT = 2'b01,
        SCS_SW_GAP = 2'b11
    } scs_sw_t;

    typedef struct packed {
        scs_sw_t sw;
        logic init;
        logic [2:0] requested_clock_source;
        logic [3:0] requested_clock_divider;
        logic [2:0] cosc;
        logic [3:0] cdiv;
        logic hold;
        logic nsr;
        logic done;
        logic [3:0] frq;
        logic [5:0] trim;
        logic [5:0] men;
        logic [9:0] crystal_startup_counter;
        logic ost_ok;
        logic xin_q;
        logic [8:0] div;
        logic tick;
        logic gate;
        logic [31:0] rdata;
    } scs_state_t;
endpackage

// [scs_clock_select.sv]
/*
 * scs_clock_select.sv: system clock source selection, crystal start-up
 * counter, post-divider, fast rc trim, ready status and manual enables.
 * assumes: apb master on pclk; oscillator ready levels and the sampled
 * crystal input level are synchronous to pclk; configuration inputs are
 * stable from reset onward.
 */
// The register offsets and register access over APB were left to the implementer.
// Functional notes
// - crystal modes wait 1024 crystal input cycles before external source is ready
// - start-up count restarts after power-on reset, brown-out reset and wake-up
// - external source with 4x multiplier chosen by reset select or request field
// - secondary 32k oscillator selectable at run time by clock switching
// - pin output enable configuration decides crystal out pin carries clock output outside crystal modes
// - reset select 110 starts fast rc at 1 MHz, 000 at 16 MHz doubled to 32 MHz
// - four-bit frequency select field sets fast rc frequency
// - divider field divides selected source from 1:1 to 1:512
// - 2x multiplier accepts only 8, 12, 16 MHz fast rc inputs
// - reset select 000 loads frequency field 110 and enables 2x multiplier
// - trim is six-bit two's complement, resets to 00h, fast rc only
// - trim 1Fh is highest adjustment, 20h lowest
// - trim change takes effect gradually with no completion indication
// - trim writes never touch slow rc frequency
// - slow rc always runs for timers and monitor, also selectable
// - slow rc selectable by reset select or run-time request
// - ready status register shows one ready bit per oscillator
// - manual enable register turns oscillators on; software polls ready
// - six selectable sources at run time
// - external clock input mode skips start-up count entirely
// - current clock keeps running until requested source is ready
// - ready source with hold clear completes switch, sets ready and done flags
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module scs_clock_select
    import scs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] reset_clock_select,
    input wire logic [2:0] ext_mode,
    input wire logic clock_pin_output_enable,
    input wire logic por_event,
    input wire logic brownout_reset,
    input wire logic wake_event,
    input wire logic crystal_in_pin,
    input wire logic fast_rc_ok,
    input wire logic slow_rc_ok,
    input wire logic sec_osc_ok,
    input wire logic pll4_lock,
    input wire logic pll2_lock,
    output logic [5:0] osc_enable,
    output logic [3:0] fast_rc_freq_select,
    output logic [5:0] fast_rc_trim,
    output logic [2:0] clk_mux_sel,
    output logic clk_mux_gate,
    output logic sys_clk_en,
    output logic crystal_out_clkout
);

    // ------------------------------------------------------------------
    // decoding functions
    // ------------------------------------------------------------------

    // oscillators that a source code needs
    function automatic logic [5:0] src_need(input logic [2:0] s);
        logic [5:0] n;
        n = 6'h00;
        case (s)
            `SCS_SRC_HF2X: n = 6'h22;
            `SCS_SRC_EXT4X: n = 6'h11;
            `SCS_SRC_SEC: n = 6'h08;
            `SCS_SRC_LF: n = 6'h04;
            `SCS_SRC_EXT: n = 6'h01;
            `SCS_SRC_HF: n = 6'h02;
            default: n = 6'h00;
        endcase
        return n;
    endfunction

    function automatic logic src_valid(input logic [2:0] s);
        return src_need(s) != 6'h00;
    endfunction

    function automatic logic is_crystal(input logic [2:0] m);
        return m == `SCS_MODE_LP || m == `SCS_MODE_XT || m == `SCS_MODE_HS;
    endfunction

    // ------------------------------------------------------------------
    // state and derived levels
    // ------------------------------------------------------------------
    scs_state_t st_ff;
    scs_state_t nxt_st;
    logic [5:0] rdy;
    logic [5:0] en;
    logic frq_pll_ok;
    logic new_rdy;
    logic setup;
    logic wr;
    logic hit;
    logic restart;
    logic xin_rise;
    logic [8:0] div_last;

    // oscillator enables: requested, current and manual
    always_comb
    begin
        en = src_need(st_ff.requested_clock_source) | src_need(st_ff.cosc) | st_ff.men;
        en[`SCS_O_LF] = 1'b1;
    end

    // only 8, 12 and 16 MHz feed the 2x multiplier
    assign frq_pll_ok = st_ff.frq == `SCS_FRQ_8M || st_ff.frq == `SCS_FRQ_12M
        || st_ff.frq == `SCS_FRQ_16M;

    // ready status per oscillator
    always_comb
    begin
        rdy = 6'h00;
        rdy[`SCS_O_EXT] = en[`SCS_O_EXT] & (!is_crystal(ext_mode) | st_ff.ost_ok);
        rdy[`SCS_O_HF] = en[`SCS_O_HF] & fast_rc_ok;
        rdy[`SCS_O_LF] = slow_rc_ok;
        rdy[`SCS_O_SEC] = en[`SCS_O_SEC] & sec_osc_ok;
        rdy[`SCS_O_PLL4] = en[`SCS_O_PLL4] & pll4_lock & rdy[`SCS_O_EXT];
        rdy[`SCS_O_PLL2] = en[`SCS_O_PLL2] & pll2_lock & rdy[`SCS_O_HF] & frq_pll_ok;
    end

    assign new_rdy = (src_need(st_ff.requested_clock_source) & rdy) == src_need(st_ff.requested_clock_source);
    assign setup = psel & !penable;
    assign wr = psel & penable & pwrite;
    assign hit = paddr[11:5] == 7'h00 && paddr[1:0] == 2'b00;
    assign restart = por_event | brownout_reset | wake_event;
    assign xin_rise = crystal_in_pin & !st_ff.xin_q;
    assign div_last = 9'((10'h001 << st_ff.cdiv) - 10'h001);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.xin_q = crystal_in_pin;
        nxt_st.nsr = 1'b0;

        // reset-time selection, taken once after release
        if (!st_ff.init)
        begin
            nxt_st.init = 1'b1;
            nxt_st.cosc = reset_clock_select;
            nxt_st.requested_clock_source = reset_clock_select;
            if (reset_clock_select == `SCS_SRC_HF2X)
                nxt_st.frq = `SCS_FRQ_16M;
            else if (reset_clock_select == `SCS_SRC_HF)
                nxt_st.frq = `SCS_FRQ_1M;
        end

        // crystal start-up counter
        if (restart || !en[`SCS_O_EXT] || !is_crystal(ext_mode))
        begin
            nxt_st.crystal_startup_counter = 10'h000;
            nxt_st.ost_ok = 1'b0;
        end
        else if (xin_rise && !st_ff.ost_ok)
        begin
            nxt_st.crystal_startup_counter = st_ff.crystal_startup_counter + 10'h001;
            if (st_ff.crystal_startup_counter == `SCS_OST_LAST)
                nxt_st.ost_ok = 1'b1;
        end

        // post-divider enable pulses
        nxt_st.tick = 1'b0;
        if (st_ff.div >= div_last)
        begin
            nxt_st.div = 9'h000;
            nxt_st.tick = st_ff.gate;
        end
        else
            nxt_st.div = st_ff.div + 9'h001;

        // switch sequencer
        nxt_st.gate = 1'b1;
        case (st_ff.sw)
            SCS_SW_IDLE:
            begin
                if (st_ff.init && (st_ff.requested_clock_source != st_ff.cosc || st_ff.requested_clock_divider != st_ff.cdiv))
                    nxt_st.sw = SCS_SW_WAIT;
            end
            SCS_SW_WAIT:
            begin
                if (st_ff.requested_clock_source == st_ff.cosc && st_ff.requested_clock_divider == st_ff.cdiv)
                    nxt_st.sw = SCS_SW_IDLE;
                else if (new_rdy)
                begin
                    nxt_st.nsr = 1'b1;
                    nxt_st.done = 1'b1;
                    if (!st_ff.hold)
                    begin
                        nxt_st.sw = SCS_SW_GAP;
                        nxt_st.gate = 1'b0;
                    end
                end
            end
            SCS_SW_GAP:
            begin
                nxt_st.cosc = st_ff.requested_clock_source;
                nxt_st.cdiv = st_ff.requested_clock_divider;
                nxt_st.div = 9'h000;
                nxt_st.sw = SCS_SW_IDLE;
            end
            default: nxt_st.sw = SCS_SW_IDLE;
        endcase

        // register writes
        if (wr && hit)
        begin
            case (paddr)
                `SCS_OFS_REQUEST:
                begin
                    if (src_valid(pwdata[6:4]))
                        nxt_st.requested_clock_source = pwdata[6:4];
                    nxt_st.requested_clock_divider = pwdata[3:0] > `SCS_DIV_MAX ? `SCS_DIV_MAX : pwdata[3:0];
                end
                `SCS_OFS_SWITCH: nxt_st.hold = pwdata[`SCS_HOLD_BIT];
                `SCS_OFS_MANUAL: nxt_st.men = pwdata[5:0];
                `SCS_OFS_FREQ: nxt_st.frq = pwdata[3:0];
                `SCS_OFS_TRIM: nxt_st.trim = pwdata[5:0];
                `SCS_OFS_DONE:
                begin
                    if (pwdata[0] && !nxt_st.done)
                        nxt_st.done = 1'b0;
                    else if (pwdata[0] && !(st_ff.sw == SCS_SW_WAIT && new_rdy))
                        nxt_st.done = 1'b0;
                end
                default: nxt_st.men = nxt_st.men;
            endcase
        end

        // read data captured in the setup cycle
        if (setup)
        begin
            nxt_st.rdata = 32'h0000_0000;
            case (paddr)
                `SCS_OFS_REQUEST: nxt_st.rdata[6:0] = {st_ff.requested_clock_source, st_ff.requested_clock_divider};
                `SCS_OFS_CURRENT: nxt_st.rdata[6:0] = {st_ff.cosc, st_ff.cdiv};
                `SCS_OFS_SWITCH:
                begin
                    nxt_st.rdata[`SCS_HOLD_BIT] = st_ff.hold;
                    nxt_st.rdata[`SCS_NSR_BIT] = st_ff.sw == SCS_SW_WAIT && new_rdy;
                    nxt_st.rdata[`SCS_ORDY_BIT] = st_ff.sw == SCS_SW_IDLE;
                end
                `SCS_OFS_READY: nxt_st.rdata[5:0] = rdy;
                `SCS_OFS_MANUAL: nxt_st.rdata[5:0] = st_ff.men;
                `SCS_OFS_FREQ: nxt_st.rdata[3:0] = st_ff.frq;
                `SCS_OFS_TRIM: nxt_st.rdata[5:0] = st_ff.trim;
                `SCS_OFS_DONE: nxt_st.rdata[0] = st_ff.done;
                default: nxt_st.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_ff <= '0;
            st_ff.trim <= `SCS_TRIM_RST;
            st_ff.gate <= 1'b1;
        end
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata = st_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & !hit;
    assign osc_enable = en;
    assign fast_rc_freq_select = st_ff.frq;
    assign fast_rc_trim = st_ff.trim;
    assign clk_mux_sel = st_ff.cosc;
    assign clk_mux_gate = st_ff.gate;
    assign sys_clk_en = st_ff.tick;
    assign crystal_out_clkout = clock_pin_output_enable & !is_crystal(ext_mode);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ready_go;
        st_ff.sw == SCS_SW_WAIT && new_rdy && !st_ff.hold && st_ff.requested_clock_source != st_ff.cosc;
    endsequence

    sequence s_gap_then_switch;
        !clk_mux_gate ##1 (clk_mux_sel == $past(st_ff.requested_clock_source) && clk_mux_gate);
    endsequence

    chk_switch_glitch_free: assert property (s_ready_go |=> s_gap_then_switch)
        else $error("switch did not pass one gated cycle");
    chk_hold_blocks_switch: assert property
        (st_ff.sw == SCS_SW_WAIT && st_ff.hold |=> st_ff.sw != SCS_SW_GAP)
        else $error("switch went ahead while held");
    chk_current_kept: assert property
        (st_ff.sw == SCS_SW_WAIT |=> $stable(clk_mux_sel))
        else $error("current source changed while waiting");
    chk_done_flag_set: assert property (s_ready_go |=> st_ff.done)
        else $error("done flag not set on ready source");
    chk_ost_full_count: assert property
        ($rose(st_ff.ost_ok) |-> $past(st_ff.crystal_startup_counter) == `SCS_OST_LAST && $past(xin_rise))
        else $error("start-up count ended early");
    chk_ost_restart: assert property (restart |=> !st_ff.ost_ok && st_ff.crystal_startup_counter == 10'h000)
        else $error("start-up count not restarted");
    chk_ec_no_wait: assert property
        (en[`SCS_O_EXT] && !is_crystal(ext_mode) |-> rdy[`SCS_O_EXT])
        else $error("external clock mode waited");
    chk_pll2_input: assert property (rdy[`SCS_O_PLL2] |-> frq_pll_ok)
        else $error("2x multiplier ready on bad input");
    chk_div_one_rate: assert property
        (st_ff.cdiv == 4'h0 && st_ff.gate && st_ff.sw == SCS_SW_IDLE |=> sys_clk_en)
        else $error("divide by one missed a pulse");
    chk_reset_fast_rc: assert property
        (!st_ff.init && reset_clock_select == `SCS_SRC_HF2X |=> fast_rc_freq_select == `SCS_FRQ_16M)
        else $error("reset select did not load 16 MHz");
    chk_slow_rc_on: assert property (osc_enable[`SCS_O_LF])
        else $error("slow rc switched off");

endmodule
`default_nettype wire

// [scs_osc_model.sv]
/*
 * scs_osc_model.sv: oscillators and crystal beside the clock select block.
 * assumes: one pclk domain; enables come from the block under test.
 */
`timescale 1ns/1ps
`default_nettype none

module scs_osc_model
    import scs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic [5:0] osc_enable,
    output logic crystal_in_pin,
    output logic [5:0] ok
);
    logic [5:0] d1_ff, d2_ff, d3_ff;
    logic xin_ff;

    // ----------------------------------------------------------------
    // ready levels trail enables; crystal swings only while driven
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            d1_ff <= 6'h00;
            d2_ff <= 6'h00;
            d3_ff <= 6'h00;
            xin_ff <= 1'b0;
        end
        else
        begin
            d1_ff <= osc_enable;
            d2_ff <= d1_ff & osc_enable;
            d3_ff <= d2_ff & osc_enable;
            xin_ff <= osc_enable[0] & ~xin_ff;
        end
    end
    assign ok = (slow ? d3_ff : d1_ff) & osc_enable;
    assign crystal_in_pin = xin_ff;
endmodule
`default_nettype wire

// [system_clock_source_select_bench.sv]
/*
 * system_clock_source_select_bench.sv: self-checking bench, apb tasks and tests.
 * assumes: scs_pkg and scs_osc_model compiled first; scs_defs.svh on the path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scs_defs.svh"

module system_clock_source_select_bench
    import scs_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic cpoe, slow, gate, sys_en, clkout, e, p, xin, g;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [2:0] rsel, ext_mode, mux_sel, ev;
    logic [5:0] ok, osc_en, trim;
    logic [3:0] frq;
    logic [2:0] srcs [6];
    int mismatches, cmp_count, cycles, n;

    scs_clock_select dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_clock_select(rsel), .ext_mode(ext_mode),
        .clock_pin_output_enable(cpoe), .por_event(ev[0]), .brownout_reset(ev[1]),
        .wake_event(ev[2]), .crystal_in_pin(xin), .fast_rc_ok(ok[1]), .slow_rc_ok(ok[2]),
        .sec_osc_ok(ok[3]), .pll4_lock(ok[4]), .pll2_lock(ok[5]), .osc_enable(osc_en),
        .fast_rc_freq_select(frq), .fast_rc_trim(trim), .clk_mux_sel(mux_sel),
        .clk_mux_gate(gate), .sys_clk_en(sys_en), .crystal_out_clkout(clkout));

    scs_osc_model osc_u (.pclk(pclk), .presetn(presetn), .slow(slow), .osc_enable(osc_en),
        .crystal_in_pin(xin), .ok(ok));

    // ----------------------------------------------------------------
    // clock, timeout and closing report
    // ----------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // compare, apb cycles and waits; entered just after a rising edge
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // access lasts until pready is seen high at a rising edge; answer taken there
        do
        begin
            @(posedge pclk);
            q = prdata;
            e = pslverr;
            p = pready;
        end while (p !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge so written state shows and the next setup starts cleanly
        @(posedge pclk);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask

    task automatic wait_src(input logic [2:0] s);
        g = 1'b0;
        n = 0;
        while (mux_sel !== s && n < 300)
        begin
            @(negedge pclk);
            if (gate === 1'b0)
                g = 1'b1;
            n++;
        end
        @(posedge pclk);
        chk(32'(g), 32'h1);
        chk(32'(mux_sel), 32'(s));
    endtask

    task automatic xedges(input int k);
        n = 0;
        p = xin;
        while (n < k)
        begin
            @(negedge pclk);
            if (xin === 1'b1 && p === 1'b0)
                n++;
            p = xin;
        end
        @(posedge pclk);
    endtask

    task automatic do_reset(input logic [2:0] code);
        rsel <= code;
        presetn <= 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, ev, slow} = '0;
        {rsel, ext_mode, cpoe, mismatches, cmp_count, cycles} = '0;
        srcs = '{`SCS_SRC_HF2X, `SCS_SRC_EXT4X, `SCS_SRC_SEC, `SCS_SRC_LF, `SCS_SRC_EXT, `SCS_SRC_HF};
        cpoe = 1'b1;
        do_reset(`SCS_SRC_HF);
        rdc(`SCS_OFS_CURRENT, 32'h60);
        rdc(`SCS_OFS_FREQ, 32'h0);
        rdc(`SCS_OFS_TRIM, 32'h0);
        chk(32'(clkout), 32'h1);
        apb(1'b1, `SCS_OFS_TRIM, 32'h1f);
        chk(32'(trim), 32'h1f);
        apb(1'b1, `SCS_OFS_TRIM, 32'h20);
        rdc(`SCS_OFS_TRIM, 32'h20);
        rdc(`SCS_OFS_DONE, 32'h0);
        apb(1'b0, `SCS_OFS_READY, 32'h0);
        chk(32'(q[2] & osc_en[2]), 32'h1);
        apb(1'b1, `SCS_OFS_FREQ, 32'h5);
        chk(32'(frq), 32'h5);
        apb(1'b0, 12'h020, 32'h0);
        chk({q[30:0], e}, 32'h1);
        // every source in turn, old one kept until the new is ready
        slow = 1'b1;
        apb(1'b1, `SCS_OFS_FREQ, 32'h6);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `SCS_OFS_REQUEST, {25'h0, srcs[i], 4'h1});
            chk(32'(mux_sel), 32'(srcs[(i + 5) % 6]));
            wait_src(srcs[i]);
            rdc(`SCS_OFS_CURRENT, {25'h0, srcs[i], 4'h1});
            rdc(`SCS_OFS_DONE, 32'h1);
            apb(1'b1, `SCS_OFS_DONE, 32'h1);
        end
        rdc(`SCS_OFS_DONE, 32'h0);
        // unassigned source code keeps the old source, divider still taken
        apb(1'b1, `SCS_OFS_REQUEST, 32'h51);
        rdc(`SCS_OFS_REQUEST, 32'h61);
        // hold stops the switch until released
        apb(1'b1, `SCS_OFS_SWITCH, 32'h80);
        apb(1'b1, `SCS_OFS_REQUEST, 32'h30);
        repeat (20) @(posedge pclk);
        chk(32'(mux_sel), 32'h6);
        apb(1'b0, `SCS_OFS_SWITCH, 32'h0);
        chk(32'(q[4]), 32'h1);
        apb(1'b1, `SCS_OFS_SWITCH, 32'h0);
        wait_src(`SCS_SRC_LF);
        // divider: pulses in 1024 cycles for ratios 1, 16 and clamped 512
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, `SCS_OFS_DONE, 32'h1);
            apb(1'b1, `SCS_OFS_REQUEST, 32'(48 + (i == 1 ? 4 : 0) + (i == 2 ? 15 : 0)));
            repeat (30) @(posedge pclk);
            n = 0;
            repeat (1024)
            begin
                @(negedge pclk);
                n += int'(sys_en === 1'b1);
            end
            @(posedge pclk);
            chk(32'(n), 32'(1024 >> (i * 4 + (i / 2))));
        end
        rdc(`SCS_OFS_CURRENT, 32'h39);
        // 2x path refuses 1 MHz input, runs at 8 MHz
        apb(1'b1, `SCS_OFS_FREQ, 32'h0);
        apb(1'b1, `SCS_OFS_REQUEST, 32'h00);
        repeat (30) @(posedge pclk);
        chk(32'(mux_sel), 32'h3);
        apb(1'b1, `SCS_OFS_FREQ, 32'h4);
        wait_src(`SCS_SRC_HF2X);
        // crystal start-up count in each crystal mode and after each event
        apb(1'b1, `SCS_OFS_MANUAL, 32'h09);
        chk(32'(clkout), 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            ext_mode <= 3'(3 + k % 3);
            if (k > 0)
                ev <= 3'(1 << (k - 1));
            @(posedge pclk);
            ev <= 3'h0;
            xedges(1020);
            apb(1'b0, `SCS_OFS_READY, 32'h0);
            chk(32'(q[0]), 32'h0);
            xedges(10);
            apb(1'b0, `SCS_OFS_READY, 32'h0);
            chk(32'({q[3], q[0]}), 32'h3);
        end
        chk(32'(clkout), 32'h0);
        ext_mode <= `SCS_MODE_ECH;
        ev <= 3'h1;
        @(posedge pclk);
        ev <= 3'h0;
        cpoe <= 1'b0;
        apb(1'b0, `SCS_OFS_READY, 32'h0);
        chk(32'({clkout, q[0]}), 32'h1);
        // reset straight into the doubled fast rc
        do_reset(`SCS_SRC_HF2X);
        rdc(`SCS_OFS_CURRENT, 32'h0);
        rdc(`SCS_OFS_FREQ, 32'h6);
        chk(32'(osc_en[5]), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
